// >>> core/qwr_pkg.sv
//==========================================================
// Shared constants for the quad wrap read link
package qwr_pkg;
  // Clock and timing
  localparam int SYS_CLK_MHZ = 20;
  localparam int SYS_CLK_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int SCLK_HALF_CYC = (LINK_PERIOD_NS / 2) / SYS_CLK_NS;
  localparam int T_RST_US = 30;
  localparam int RST_CYCLES = T_RST_US * SYS_CLK_MHZ;
  localparam int RST_CNT_W = 10;

  //==========================================================
  // Opcodes
  localparam logic [7:0] OP_WORD_QREAD = 8'hE7;
  localparam logic [7:0] OP_FAST_QREAD = 8'hEB;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_QPI_FAST = 8'h0B;
  localparam logic [7:0] OP_QPI_WRAP = 8'h0C;
  localparam logic [7:0] OP_READ_PARAM = 8'hC0;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;

  //==========================================================
  // Phase lengths in link clocks
  localparam logic [5:0] CMD_CLK_SPI = 6'h08;
  localparam logic [5:0] CMD_CLK_QPI = 6'h02;
  localparam logic [5:0] ADDR_CLK = 6'h06;
  localparam logic [5:0] MODE_CLK = 6'h02;
  localparam logic [5:0] PAY_CLK_WRAP = 6'h08;
  localparam logic [5:0] PAY_CLK_PARAM = 6'h02;
  localparam logic [5:0] DUMMY_WORD = 6'h02;
  localparam logic [5:0] DUMMY_4 = 6'h04;
  localparam logic [5:0] DUMMY_6 = 6'h06;
  localparam logic [5:0] DUMMY_8 = 6'h08;

  //==========================================================
  // Continuous mode key, field positions and reset values
  localparam logic [3:0] CONT_MODE_KEY = 4'hA;
  localparam int WRAP_OFF_BIT = 4;
  localparam int WRAP_LEN_LO = 5;
  localparam int DUMMY_SEL_LO = 4;
  localparam int WRAP_SIZE_LO = 0;
  localparam logic RST_WRAP_OFF = 1'b1;
  localparam logic [1:0] RST_WRAP_LEN = 2'h0;
  localparam logic [1:0] RST_DUMMY_SEL = 2'h0;
endpackage

// >>> core/qwr_link_if.sv
`timescale 1ns/1ps
//==========================================================
// Serial link between host controller and flash command logic
interface qwr_link_if;
  logic csN;
  logic sclk;
  logic [3:0] hostIoOut;
  logic [3:0] hostIoOe;
  logic [3:0] devIoOut;
  logic [3:0] devIoOe;
  logic [3:0] io;

  // Resolved IO level, pulled up when nobody drives
  assign io = (devIoOe & devIoOut) | (~devIoOe & hostIoOe & hostIoOut) | (~devIoOe & ~hostIoOe);

  modport device (input csN, input sclk, input io, output devIoOut, output devIoOe);
  modport host (output csN, output sclk, output hostIoOut, output hostIoOe, input io);
endinterface

// >>> core/qwr_flash_device.sv
//==========================================================
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module qwr_flash_device
  import qwr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  qwr_link_if.device link,
  input wire logic quadPermit,
  input wire logic qpiMode,
  input wire logic [7:0] memData,
  output logic [23:0] memAddr,
  output logic wrapDisable,
  output logic [1:0] wrapLength,
  output logic [1:0] dummySelect,
  output logic continuousMode,
  output logic resetBusy,
  output logic softResetPulse
);

  typedef enum logic [3:0] {
    QWR_D_IDLE, QWR_D_CMD, QWR_D_ADDR, QWR_D_MODE, QWR_D_DUMMY,
    QWR_D_DATA, QWR_D_PAY, QWR_D_HOLD, QWR_D_IGNORE
  } qwr_dev_state_type;

  //==========================================================
  // Link input synchronisers
  logic sclkMeta, sclkSync, sclkPrev;
  logic csMeta, csSync, csPrev;
  logic [3:0] ioMeta, ioSync;

  // Two flops per pin, then edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkPrev <= 1'b0;
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csPrev <= 1'b1;
      ioMeta <= 4'h0;
      ioSync <= 4'h0;
    end else begin
      sclkMeta <= link.sclk;
      sclkSync <= sclkMeta;
      sclkPrev <= sclkSync;
      csMeta <= link.csN;
      csSync <= csMeta;
      csPrev <= csSync;
      ioMeta <= link.io;
      ioSync <= ioMeta;
    end
  end

  logic rise, fall, csRise, csFall;
  assign rise = sclkSync & ~sclkPrev;
  assign fall = ~sclkSync & sclkPrev;
  assign csRise = csSync & ~csPrev;
  assign csFall = ~csSync & csPrev;

  //==========================================================
  // Command state
  qwr_dev_state_type state, next_state;
  logic [5:0] cnt, next_cnt;
  logic [31:0] shIn, next_shIn;
  logic [7:0] cmd, next_cmd;
  logic [23:0] addr, next_addr;
  logic [23:0] next_memAddr;
  logic [3:0] loNib, next_loNib;
  logic nibHi, next_nibHi;
  logic [3:0] ioOut, next_ioOut;
  logic [3:0] ioOe, next_ioOe;
  logic armed, next_armed;
  logic next_wrapDisable, next_continuousMode, next_softResetPulse;
  logic [1:0] next_wrapLength, next_dummySelect;
  logic [RST_CNT_W-1:0] rstCnt, next_rstCnt;

  logic [31:0] inWord;
  logic [5:0] cntInc;
  logic [5:0] cmdClk;
  logic [5:0] dummyClk;
  logic [5:0] lenMask;
  logic wrapOn;
  logic [23:0] addrStep;

  // Dummy clocks for the current read
  function automatic logic [5:0] qwr_param_dummy(input logic [1:0] sel);
    logic [5:0] d;
    d = DUMMY_4;
    if (sel == 2'h2) d = DUMMY_6;
    if (sel == 2'h3) d = DUMMY_8;
    return d;
  endfunction

  // Shift input, phase lengths and wrapped address step
  always_comb begin
    if (state == QWR_D_CMD && !qpiMode) inWord = {shIn[30:0], ioSync[0]};
    else inWord = {shIn[27:0], ioSync};
    cntInc = cnt + 6'h01;
    cmdClk = qpiMode ? CMD_CLK_QPI : CMD_CLK_SPI;
    if (cmd == OP_WORD_QREAD) dummyClk = DUMMY_WORD;
    else if (cmd == OP_FAST_QREAD && !qpiMode) dummyClk = DUMMY_4;
    else dummyClk = qwr_param_dummy(dummySelect);
    lenMask = (6'h08 << wrapLength) - 6'h01;
    // Stored wrap disable bit governs only the two quad I/O reads; plain fast read never wraps
    wrapOn = (cmd == OP_QPI_WRAP) ||
      (!wrapDisable && (cmd == OP_WORD_QREAD || cmd == OP_FAST_QREAD));
    if (wrapOn) begin
      addrStep = {memAddr[23:6], (memAddr[5:0] & ~lenMask) | ((memAddr[5:0] + 6'h01) & lenMask)};
    end else begin
      addrStep = memAddr + 24'h000001;
    end
  end

  // Next values of the command state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shIn = shIn;
    next_cmd = cmd;
    next_addr = addr;
    next_memAddr = memAddr;
    next_loNib = loNib;
    next_nibHi = nibHi;
    next_ioOut = ioOut;
    next_ioOe = ioOe;
    next_armed = armed;
    next_wrapDisable = wrapDisable;
    next_wrapLength = wrapLength;
    next_dummySelect = dummySelect;
    next_continuousMode = continuousMode;
    next_softResetPulse = 1'b0;
    next_rstCnt = (rstCnt != '0) ? rstCnt - 1'b1 : rstCnt;
    if (csRise) begin
      if (state == QWR_D_PAY && cmd == OP_SET_WRAP && cnt == PAY_CLK_WRAP) begin
        next_wrapDisable = shIn[WRAP_OFF_BIT];
        next_wrapLength = shIn[WRAP_LEN_LO +: 2];
      end else if (state == QWR_D_PAY && cmd == OP_READ_PARAM && cnt == PAY_CLK_PARAM) begin
        next_dummySelect = shIn[DUMMY_SEL_LO +: 2];
        next_wrapLength = shIn[WRAP_SIZE_LO +: 2];
      end else if (state == QWR_D_HOLD && cmd == OP_RST_EN) begin
        next_armed = 1'b1;
      end else if (state == QWR_D_HOLD && armed) begin
        // Accepted soft reset back to power on defaults
        next_armed = 1'b0;
        next_softResetPulse = 1'b1;
        next_continuousMode = 1'b0;
        next_wrapDisable = RST_WRAP_OFF;
        next_wrapLength = RST_WRAP_LEN;
        next_dummySelect = RST_DUMMY_SEL;
        next_rstCnt = RST_CNT_W'(RST_CYCLES);
      end else if (state == QWR_D_HOLD) begin
        next_armed = 1'b0;
      end
      next_state = QWR_D_IDLE;
      next_ioOe = 4'h0;
    end else if (csFall) begin
      next_cnt = 6'h00;
      if (rstCnt != '0) next_state = QWR_D_IGNORE;
      else if (continuousMode) next_state = QWR_D_ADDR;
      else next_state = QWR_D_CMD;
    end else if (rise) begin
      next_shIn = inWord;
      next_cnt = (cnt == 6'h3F) ? cnt : cntInc;
      unique case (state)
        QWR_D_CMD: begin
          if (cntInc == cmdClk) begin
            next_cmd = inWord[7:0];
            next_cnt = 6'h00;
            if (inWord[7:0] != OP_RST_EN && inWord[7:0] != OP_RST) begin
              next_armed = 1'b0;
            end
            if (inWord[7:0] == OP_WORD_QREAD || inWord[7:0] == OP_FAST_QREAD) begin
              next_state = quadPermit ? QWR_D_ADDR : QWR_D_IGNORE;
            end else if (inWord[7:0] == OP_SET_WRAP) begin
              next_state = quadPermit ? QWR_D_PAY : QWR_D_IGNORE;
            end else if (inWord[7:0] == OP_READ_PARAM) begin
              next_state = qpiMode ? QWR_D_PAY : QWR_D_IGNORE;
            end else if (inWord[7:0] == OP_QPI_FAST || inWord[7:0] == OP_QPI_WRAP) begin
              next_state = qpiMode ? QWR_D_ADDR : QWR_D_IGNORE;
            end else if (inWord[7:0] == OP_RST_EN || inWord[7:0] == OP_RST) begin
              next_state = QWR_D_HOLD;
            end else begin
              next_state = QWR_D_IGNORE;
            end
          end
        end
        QWR_D_ADDR: begin
          if (cntInc == ADDR_CLK) begin
            next_cnt = 6'h00;
            next_addr = inWord[23:0];
            if (cmd == OP_WORD_QREAD) next_addr[0] = 1'b0;
            if (cmd == OP_WORD_QREAD || cmd == OP_FAST_QREAD) next_state = QWR_D_MODE;
            else next_state = QWR_D_DUMMY;
          end
        end
        QWR_D_MODE: begin
          if (cntInc == MODE_CLK) begin
            next_cnt = 6'h00;
            next_continuousMode = (inWord[7:4] == CONT_MODE_KEY);
            next_state = QWR_D_DUMMY;
          end
        end
        QWR_D_DUMMY: begin
          if (cntInc == dummyClk) begin
            next_memAddr = addr;
            next_nibHi = 1'b1;
            next_state = QWR_D_DATA;
          end
        end
        QWR_D_HOLD: next_state = QWR_D_IGNORE;
        QWR_D_IDLE, QWR_D_DATA, QWR_D_PAY, QWR_D_IGNORE: ;
      endcase
    end else if (fall && state == QWR_D_DATA) begin
      // Drive a nibble per falling edge, high nibble first
      next_ioOe = 4'hF;
      if (nibHi) begin
        next_ioOut = memData[7:4];
        next_loNib = memData[3:0];
        next_nibHi = 1'b0;
      end else begin
        next_ioOut = loNib;
        next_nibHi = 1'b1;
        next_memAddr = addrStep;
      end
    end
  end

  // Registers of the command state
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= QWR_D_IDLE;
      cnt <= 6'h00;
      shIn <= 32'h00000000;
      cmd <= 8'h00;
      addr <= 24'h000000;
      memAddr <= 24'h000000;
      loNib <= 4'h0;
      nibHi <= 1'b1;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      armed <= 1'b0;
      wrapDisable <= RST_WRAP_OFF;
      wrapLength <= RST_WRAP_LEN;
      dummySelect <= RST_DUMMY_SEL;
      continuousMode <= 1'b0;
      softResetPulse <= 1'b0;
      rstCnt <= '0;
      resetBusy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shIn <= next_shIn;
      cmd <= next_cmd;
      addr <= next_addr;
      memAddr <= next_memAddr;
      loNib <= next_loNib;
      nibHi <= next_nibHi;
      ioOut <= next_ioOut;
      ioOe <= next_ioOe;
      armed <= next_armed;
      wrapDisable <= next_wrapDisable;
      wrapLength <= next_wrapLength;
      dummySelect <= next_dummySelect;
      continuousMode <= next_continuousMode;
      softResetPulse <= next_softResetPulse;
      rstCnt <= next_rstCnt;
      resetBusy <= (next_rstCnt != '0);
    end
  end

  //==========================================================
  // Link outputs
  assign link.devIoOut = ioOut;
  assign link.devIoOe = ioOe;

endmodule

// >>> core/qwr_host_ctrl.sv
`timescale 1ns/1ps
module qwr_host_ctrl
  import qwr_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  qwr_link_if.host link,
  input wire logic start,
  input wire logic [7:0] cmdByte,
  input wire logic skipCmd,
  input wire logic qpiMode,
  input wire logic [31:0] payload,
  input wire logic [5:0] payClocks,
  input wire logic [5:0] dummyClocks,
  input wire logic [7:0] readBytes,
  input wire logic flashBusy,
  output logic busy,
  output logic refused,
  output logic [7:0] rdData,
  output logic rdValid
);

  typedef enum logic [1:0] {QWR_H_IDLE, QWR_H_RUN, QWR_H_GAP} qwr_host_state_type;

  //==========================================================
  // IO input synchroniser
  logic [3:0] ioMeta, ioSync;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ioMeta <= 4'h0;
      ioSync <= 4'h0;
    end else begin
      ioMeta <= link.io;
      ioSync <= ioMeta;
    end
  end

  //==========================================================
  // Transfer sequencer
  qwr_host_state_type state, next_state;
  logic [7:0] div, next_div;
  logic sclk, next_sclk, csN, next_csN;
  logic [39:0] tx, next_tx, txShift;
  logic [2:0] phase, next_phase, seekPh;
  logic [35:0] lens, next_lens, newLens;
  logic [8:0] left, next_left;
  logic qpi, next_qpi;
  logic [3:0] ioOut, next_ioOut, ioOe, next_ioOe;
  logic rxHi, next_rxHi;
  logic [3:0] rxNib, next_rxNib;
  logic [7:0] next_rdData;
  logic next_rdValid, next_refused;
  logic [1:0] autoStep, next_autoStep;
  logic issue;
  logic [7:0] issueCmd;
  logic [39:0] issueTx;

  // First phase at or after base with a nonzero length
  function automatic logic [2:0] qwr_seek(input logic [2:0] base, input logic [35:0] l);
    logic [2:0] p;
    p = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (3'(i) >= base && l[i*9 +: 9] != 9'h000) p = 3'(i);
    end
    return p;
  endfunction

  // Next values of the sequencer
  always_comb begin
    next_state = state;
    next_div = div;
    next_sclk = sclk;
    next_csN = csN;
    next_tx = tx;
    next_phase = phase;
    next_lens = lens;
    next_left = left;
    next_qpi = qpi;
    next_ioOut = ioOut;
    next_ioOe = ioOe;
    next_rxHi = rxHi;
    next_rxNib = rxNib;
    next_rdData = rdData;
    next_rdValid = 1'b0;
    next_refused = 1'b0;
    next_autoStep = autoStep;
    issue = 1'b0;
    issueCmd = (autoStep == 2'h2) ? OP_RST_EN : OP_RST;
    issueTx = {issueCmd, 32'h00000000};
    newLens = {27'h0, skipCmd ? 9'h000 : 9'(qpiMode ? CMD_CLK_QPI : CMD_CLK_SPI)};
    txShift = tx;
    seekPh = 3'h4;
    if (state == QWR_H_IDLE) begin
      if (autoStep != 2'h0) begin
        issue = 1'b1;
        next_autoStep = autoStep - 2'h1;
        newLens = {27'h0, 9'(qpiMode ? CMD_CLK_QPI : CMD_CLK_SPI)};
      end else if (start) begin
        issueTx = skipCmd ? {payload, 8'h00} : {cmdByte, payload};
        if (cmdByte == OP_WORD_QREAD) issueTx[skipCmd ? 16 : 8] = 1'b0;
        newLens = {readBytes, 1'b0, 3'h0, dummyClocks, 3'h0, payClocks, newLens[8:0]};
        if ((cmdByte == OP_RST_EN || cmdByte == OP_RST) && flashBusy) begin
          next_refused = 1'b1;
        end else begin
          issue = 1'b1;
        end
      end
      seekPh = qwr_seek(3'h0, newLens);
      if (issue && seekPh != 3'h4) begin
        next_state = QWR_H_RUN;
        next_lens = newLens;
        next_qpi = qpiMode;
        next_tx = issueTx;
        next_phase = seekPh;
        next_left = newLens[seekPh[1:0]*9 +: 9];
        next_csN = 1'b0;
        next_div = 8'h00;
        next_sclk = 1'b0;
        next_rxHi = 1'b1;
        txShift = issueTx;
      end else if (issue) begin
        next_refused = 1'b1;
      end
    end else if (div != 8'(SCLK_HALF - 1)) begin
      next_div = div + 8'h01;
    end else if (state == QWR_H_GAP) begin
      next_state = QWR_H_IDLE;
    end else begin
      next_div = 8'h00;
      next_sclk = ~sclk;
      if (sclk) begin
        // Falling edge closes one link clock
        if (phase == 3'h3) begin
          next_rxHi = ~rxHi;
          if (rxHi) begin
            next_rxNib = ioSync;
          end else begin
            next_rdData = {rxNib, ioSync};
            next_rdValid = 1'b1;
          end
        end
        if (phase == 3'h0 && !qpi) txShift = {tx[38:0], 1'b0};
        else if (phase <= 3'h1) txShift = {tx[35:0], 4'h0};
        next_tx = txShift;
        next_left = left - 9'h001;
        if (left == 9'h001) begin
          seekPh = qwr_seek(phase + 3'h1, lens);
          next_phase = seekPh;
          if (seekPh == 3'h4) begin
            next_state = QWR_H_GAP;
            next_csN = 1'b1;
          end else begin
            next_left = lens[seekPh[1:0]*9 +: 9];
          end
        end
      end
    end
    // Drive IO for the phase now in force
    if (next_phase == 3'h0 && !next_qpi) begin
      next_ioOut = {3'h0, txShift[39]};
      next_ioOe = 4'h1;
    end else if (next_phase <= 3'h1) begin
      next_ioOut = txShift[39:36];
      next_ioOe = 4'hF;
    end else begin
      next_ioOe = 4'h0;
    end
    if (next_state != QWR_H_RUN) next_ioOe = 4'h0;
  end

  // Registers of the sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= QWR_H_IDLE;
      div <= 8'h00;
      sclk <= 1'b0;
      csN <= 1'b1;
      tx <= 40'h0000000000;
      phase <= 3'h4;
      lens <= 36'h000000000;
      left <= 9'h000;
      qpi <= 1'b0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      rxHi <= 1'b1;
      rxNib <= 4'h0;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      refused <= 1'b0;
      autoStep <= 2'h2;
      busy <= 1'b1;
    end else begin
      state <= next_state;
      div <= next_div;
      sclk <= next_sclk;
      csN <= next_csN;
      tx <= next_tx;
      phase <= next_phase;
      lens <= next_lens;
      left <= next_left;
      qpi <= next_qpi;
      ioOut <= next_ioOut;
      ioOe <= next_ioOe;
      rxHi <= next_rxHi;
      rxNib <= next_rxNib;
      rdData <= next_rdData;
      rdValid <= next_rdValid;
      refused <= next_refused;
      autoStep <= next_autoStep;
      busy <= (next_state != QWR_H_IDLE) || (next_autoStep != 2'h0);
    end
  end

  //==========================================================
  // Link outputs
  assign link.csN = csN;
  assign link.sclk = sclk;
  assign link.hostIoOut = ioOut;
  assign link.hostIoOe = ioOe;

endmodule

// >>> verification/qwr_props.sv
`timescale 1ns/1ps
//==========================================================
// Link checker
module qwr_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] hostIoOe,
  input wire logic [3:0] devIoOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Frame setup and gap phases
  sequence sSetup;
    !sclk[*4];
  endsequence
  sequence sGap;
    csN[*4];
  endsequence
  a_no_fight: assert property (!((|devIoOe) && (|hostIoOe)))
    else $error("io driven by both ends");
  a_host_first_off: assert property ($rose(devIoOe[0]) |-> $past(hostIoOe) == 4'h0)
    else $error("host still drove io before data");
  a_oe_whole: assert property (devIoOe == 4'h0 || devIoOe == 4'hF)
    else $error("device enables differ");
  a_oe_in_frame: assert property ($rose(devIoOe[0]) |-> !csN)
    else $error("device drove outside a frame");
  a_dev_release: assert property (csN [*8] |-> devIoOe == 4'h0)
    else $error("device held io after select rose");
  a_sclk_idle: assert property (csN |-> !sclk)
    else $error("link clock ran while deselected");
  a_cs_gap: assert property ($rose(csN) |-> sGap)
    else $error("deselect gap too short");
  a_cs_setup: assert property ($fell(csN) |-> sSetup)
    else $error("link clock rose too soon after select");
endmodule

// >>> verification/quad_wrap_read_and_soft_reset_tb_top.sv
`timescale 1ns/1ps
//==========================================================
// Bench top
module quad_wrap_read_and_soft_reset_tb_top
  import qwr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic skip = 1'b0;
  logic qpi = 1'b0;
  logic fBusy = 1'b0;
  logic qPerm = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic [31:0] pay = 32'h0;
  logic [5:0] payClk = 6'h00;
  logic [5:0] dum = 6'h00;
  logic [7:0] nb = 8'h00;
  logic busy, refused, rdValid, wDis, cMode, rBusy, srp;
  logic [7:0] rdData;
  logic [23:0] memAddr;
  logic [1:0] wLen, dSel;
  int miscompares = 0;
  int n_compared = 0;
  int nRst = 0;
  int nRef = 0;
  integer seed = 32'hACD7BA56;
  logic [7:0] got[$];
  qwr_link_if link ();
  qwr_flash_device qwr_flash_device_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .quadPermit(qPerm), .qpiMode(qpi), .memData(memAddr[7:0] ^ 8'h5A), .memAddr(memAddr),
    .wrapDisable(wDis), .wrapLength(wLen), .dummySelect(dSel), .continuousMode(cMode),
    .resetBusy(rBusy), .softResetPulse(srp));
  qwr_host_ctrl #(.SCLK_HALF(4)) qwr_host_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .link(link), .start(start), .cmdByte(cmd), .skipCmd(skip), .qpiMode(qpi), .payload(pay),
    .payClocks(payClk), .dummyClocks(dum), .readBytes(nb), .flashBusy(fBusy), .busy(busy),
    .refused(refused), .rdData(rdData), .rdValid(rdValid));
  qwr_props qwr_props_i (.sys_clk(sys_clk), .rst_b(rst_b), .csN(link.csN),
    .sclk(link.sclk), .hostIoOe(link.hostIoOe), .devIoOe(link.devIoOe));
  // Clock
  always #25 sys_clk = ~sys_clk;
  // Collect read bytes and pulses
  always @(posedge sys_clk) begin
    if (rdValid === 1'b1) got.push_back(rdData);
    if (srp === 1'b1) nRst++;
    if (refused === 1'b1) nRef++;
  end
  //==========================================================
  // Expectation helpers
  function automatic logic [7:0] secLen(input logic [1:0] l);
    return 8'h08 << l;
  endfunction
  function automatic logic [5:0] dumFor(input logic [1:0] s);
    return (s == 2'h3) ? DUMMY_8 : (s == 2'h2) ? DUMMY_6 : DUMMY_4;
  endfunction
  //==========================================================
  // Compare, verdict, waits and transfers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic idle(input logic withRst);
    int i;
    for (i = 0; i < 9000 && (busy !== 1'b0 || (withRst && rBusy !== 1'b0)); i++) begin
      @(posedge sys_clk);
    end
    if (i == 9000) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic send(input logic [7:0] c, input logic s, input logic [31:0] p,
      input logic [5:0] pc, input logic [5:0] dc, input logic [7:0] n);
    idle(1'b0);
    got.delete();
    @(posedge sys_clk);
    start <= 1'b1;
    cmd <= c;
    skip <= s;
    pay <= p;
    payClk <= pc;
    dum <= dc;
    nb <= n;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    idle(1'b0);
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [23:0] a, input logic wrapOn, input logic [1:0] l,
      input logic [7:0] n);
    logic [23:0] m;
    m = {16'h0, secLen(l)} - 24'h1;
    check(got.size(), n);
    foreach (got[k]) begin
      check(got[k], a[7:0] ^ 8'h5A);
      a = wrapOn ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
    end
  endtask
  //==========================================================
  // Main sequence
  initial begin
    logic [23:0] a;
    logic [7:0] w;
    logic [7:0] n;
    logic [31:0] p;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    idle(1'b1);
    check(nRst, 1);
    check({wDis, wLen, dSel}, 5'h10);
    // Quad commands without the permit bit
    qPerm <= 1'b0;
    send(OP_SET_WRAP, 1'b0, 32'h0, PAY_CLK_WRAP, 6'h00, 8'h00);
    check(wDis, 1'b1);
    send(OP_WORD_QREAD, 1'b0, 32'h0, 6'h08, DUMMY_WORD, 8'h02);
    check(got[0], 8'hFF);
    qPerm <= 1'b1;
    // Every wrap length over word and fast quad reads
    for (int k = 0; k < 4; k++) begin
      p = $random(seed);
      p[6:4] = {k[1:0], 1'b0};
      send(OP_SET_WRAP, 1'b0, p, PAY_CLK_WRAP, 6'h00, 8'h00);
      check({wDis, wLen}, {1'b0, k[1:0]});
      a = $random(seed);
      w = {4'h5, 4'(k)};
      n = secLen(k[1:0]) + 8'h03;
      send(OP_WORD_QREAD, 1'b0, {a, w}, 6'h08, DUMMY_WORD, n);
      rdchk({a[23:1], 1'b0}, 1'b1, k[1:0], n);
      send(OP_FAST_QREAD, 1'b0, {a, w}, 6'h08, DUMMY_4, n);
      rdchk(a, 1'b1, k[1:0], n);
    end
    // Wrap off reads straight across a section end
    send(OP_SET_WRAP, 1'b0, 32'h10, PAY_CLK_WRAP, 6'h00, 8'h00);
    check(wDis, 1'b1);
    send(OP_WORD_QREAD, 1'b0, 32'h3C00, 6'h08, DUMMY_WORD, 8'h08);
    rdchk(24'h3C, 1'b0, 2'h0, 8'h08);
    // Continuous mode skips the opcode once
    send(OP_WORD_QREAD, 1'b0, 32'h1234A0A5, 6'h08, DUMMY_WORD, 8'h04);
    rdchk(24'h1234A0, 1'b0, 2'h0, 8'h04);
    check(cMode, 1'b1);
    send(OP_WORD_QREAD, 1'b1, 32'h00567000, 6'h08, DUMMY_WORD, 8'h04);
    rdchk(24'h005670, 1'b0, 2'h0, 8'h04);
    check(cMode, 1'b0);
    send(OP_WORD_QREAD, 1'b0, 32'h00888800, 6'h08, DUMMY_WORD, 8'h02);
    rdchk(24'h008888, 1'b0, 2'h0, 8'h02);
    // Parameters refused in SPI, wrap length kept into QPI
    send(OP_SET_WRAP, 1'b0, 32'h40, PAY_CLK_WRAP, 6'h00, 8'h00);
    send(OP_READ_PARAM, 1'b0, 32'h33000000, PAY_CLK_PARAM, 6'h00, 8'h00);
    check({dSel, wLen}, 4'h2);
    qpi <= 1'b1;
    @(posedge sys_clk);
    check(wLen, 2'h2);
    // Every dummy select code over QPI wrap bursts, wrap length random
    for (int k = 0; k < 4; k++) begin
      w = $random(seed);
      w[5:4] = k[1:0];
      send(OP_READ_PARAM, 1'b0, {w, 24'h0}, PAY_CLK_PARAM, 6'h00, 8'h00);
      check({dSel, wLen}, {w[5:4], w[1:0]});
      a = $random(seed);
      n = secLen(w[1:0]) + 8'h02;
      send(OP_QPI_WRAP, 1'b0, {a, 8'h00}, ADDR_CLK, dumFor(w[5:4]), n);
      rdchk(a, 1'b1, w[1:0], n);
    end
    // Reset arm cancelled, refused while busy, then accepted
    send(OP_RST_EN, 1'b0, 32'h0, 6'h00, 6'h00, 8'h00);
    send(OP_QPI_FAST, 1'b0, 32'h00003E00, ADDR_CLK, dumFor(w[5:4]), 8'h04);
    rdchk(24'h00003E, 1'b0, 2'h0, 8'h04);
    send(OP_RST, 1'b0, 32'h0, 6'h00, 6'h00, 8'h00);
    check(nRst, 1);
    fBusy <= 1'b1;
    send(OP_RST_EN, 1'b0, 32'h0, 6'h00, 6'h00, 8'h00);
    check(nRef, 1);
    fBusy <= 1'b0;
    send(OP_RST_EN, 1'b0, 32'h0, 6'h00, 6'h00, 8'h00);
    send(OP_RST, 1'b0, 32'h0, 6'h00, 6'h00, 8'h00);
    check({nRst[1:0], rBusy}, 3'h5);
    send(OP_SET_WRAP, 1'b0, 32'h0, PAY_CLK_WRAP, 6'h00, 8'h00);
    check(wDis, 1'b1);
    idle(1'b1);
    check({wDis, wLen, dSel, cMode}, 6'h20);
    test_done();
  end
endmodule
